// *** gpt_cfg.svh ***
// Constants for the edge-count/edge-time timer block.
// Assumes a 20 MHz system clock; included by the timer and the test bench.
`ifndef GPT_CFG_SVH
`define GPT_CFG_SVH
`define GPT_HALF_W 16
`define GPT_FULL_W 32
`define GPT_LOAD_RST 16'hFFFF
`define GPT_MATCH_RST 16'h0000
`define GPT_EDGE_POS 2'h1
`define GPT_EDGE_NEG 2'h2
`define GPT_EDGE_BOTH 2'h3
`endif

// *** gpt_pkg.sv ***
// Types for the edge-count/edge-time timer block.
// Assumes gpt_cfg.svh is on the include path.
package gpt_pkg;
  typedef enum logic [1:0] {
    GPT_MODE_OFF,
    GPT_MODE_EDGE_COUNT,
    GPT_MODE_EDGE_TIME
  } gpt_mode_t;

  typedef struct packed {
    gpt_mode_t mode;
    logic [1:0] edge_sel;
    logic enable;
    logic dma_en;
  } gpt_half_cfg_t;

  typedef struct packed {
    logic match_irq;
    logic dma_req;
    logic capture;
  } gpt_half_evt_t;
endpackage

// *** gpt_timer.sv ***
// Dual-half general-purpose timer in edge-count and edge-time modes.
// Assumes capture pins are asynchronous and configuration is quasi-static.
//
// Operation
// - Decrement counter once per qualifying capture edge
// - In edge-count mode, counter reaching match value raises match interrupt
// - After match, reload interval load value and continue
// - 32-bit match compares all counter bits
// - Match raises DMA request only when enabled
// - Halves A and B both issue DMA requests; only half A when concatenated
// - Edge-time rollover alone makes no DMA request
`timescale 1ns/10ps
`include "gpt_cfg.svh"
module gpt_timer #(
  parameter int HW = `GPT_HALF_W
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Configuration
  input wire logic CFG_CONCAT,
  input wire gpt_pkg::gpt_half_cfg_t CFG_A,
  input wire gpt_pkg::gpt_half_cfg_t CFG_B,
  input wire logic [HW-1:0] INTERVAL_LOAD_A,
  input wire logic [HW-1:0] INTERVAL_LOAD_B,
  input wire logic [HW-1:0] HALF_A_MATCH_VALUE,
  input wire logic [HW-1:0] HALF_B_MATCH_VALUE,
  input wire logic LOAD_STROBE,
  // Capture pins
  input wire logic CAPTURE_INPUT_PIN_A,
  input wire logic CAPTURE_INPUT_PIN_B,
  // Status and events
  output logic [2*HW-1:0] COUNT,
  output logic [2*HW-1:0] CAPTURE_VALUE,
  output gpt_pkg::gpt_half_evt_t EVT_A,
  output gpt_pkg::gpt_half_evt_t EVT_B
);
  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  logic [1:0] sync1_ff, sync2_ff, prev_ff;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      prev_ff <= 2'h0;
    end else begin
      sync1_ff <= {CAPTURE_INPUT_PIN_B, CAPTURE_INPUT_PIN_A};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic now, input logic was);
    edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
  endfunction

  gpt_pkg::gpt_half_cfg_t cfg [2];
  assign cfg[0] = CFG_A;
  assign cfg[1] = CFG_B;
  wire [HW-1:0] load_v [2];
  wire [HW-1:0] match_v [2];
  assign load_v[0] = INTERVAL_LOAD_A;
  assign load_v[1] = INTERVAL_LOAD_B;
  assign match_v[0] = HALF_A_MATCH_VALUE;
  assign match_v[1] = HALF_B_MATCH_VALUE;

  // ==========================================================
  // Half counters
  // ==========================================================
  logic [HW-1:0] cnt_ff [2];
  logic [HW-1:0] nxt_cnt [2];
  logic [HW-1:0] cap_ff [2];
  logic [1:0] irq_ff, dma_ff, capev_ff;
  logic [1:0] hit, active, is_count, at_match, at_zero;

  // In concatenated mode half A's controls drive both halves.
  wire [2*HW-1:0] full_cnt = {cnt_ff[1], cnt_ff[0]};
  wire [2*HW-1:0] full_match = {HALF_B_MATCH_VALUE, HALF_A_MATCH_VALUE};
  wire [2*HW-1:0] full_load = {INTERVAL_LOAD_B, INTERVAL_LOAD_A};
  wire full_hit = CFG_A.enable && CFG_A.mode != gpt_pkg::GPT_MODE_OFF &&
                  edge_hit(CFG_A.edge_sel, sync2_ff[0], prev_ff[0]);
  wire full_is_count = CFG_A.mode == gpt_pkg::GPT_MODE_EDGE_COUNT;
  wire [2*HW-1:0] full_dec = full_cnt - 1'b1;
  wire full_match_hit = full_dec == full_match;
  wire [2*HW-1:0] full_next = (full_is_count && full_match_hit) ?
                              full_load : full_dec;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      assign active[g] = cfg[g].enable &&
                         cfg[g].mode != gpt_pkg::GPT_MODE_OFF;
      assign is_count[g] = cfg[g].mode == gpt_pkg::GPT_MODE_EDGE_COUNT;
      assign hit[g] = active[g] &&
                      edge_hit(cfg[g].edge_sel, sync2_ff[g], prev_ff[g]);
      wire [HW-1:0] dec_v;
      assign dec_v = cnt_ff[g] - 1'b1;
      assign at_match[g] = dec_v == match_v[g];
      assign at_zero[g] = cnt_ff[g] == '0;
      // Edge count: reload after match; either mode: reload load value at zero.
      assign nxt_cnt[g] = (is_count[g] && at_match[g]) ? load_v[g] :
                          (at_zero[g] ? load_v[g] : dec_v);
    end
  endgenerate

  wire [1:0] ev = CFG_CONCAT ? {1'b0, full_hit} : hit;
  wire [1:0] cnt_evt = CFG_CONCAT ? {1'b0, full_hit && full_is_count} :
                       (hit & is_count);
  wire [1:0] m_true = CFG_CONCAT ? {1'b0, full_match_hit} : at_match;
  wire [1:0] dma_on = {CFG_B.dma_en, CFG_A.dma_en};

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cnt_ff[0] <= `GPT_LOAD_RST;
      cnt_ff[1] <= `GPT_LOAD_RST;
    end else if (LOAD_STROBE) begin
      cnt_ff[0] <= INTERVAL_LOAD_A;
      cnt_ff[1] <= INTERVAL_LOAD_B;
    end else if (CFG_CONCAT) begin
      if (full_hit) begin
        {cnt_ff[1], cnt_ff[0]} <= full_next;
      end
    end else begin
      if (hit[0]) cnt_ff[0] <= nxt_cnt[0];
      if (hit[1]) cnt_ff[1] <= nxt_cnt[1];
    end
  end

  // ==========================================================
  // Match interrupt, DMA request and time capture pulses
  // ==========================================================
  // The match is judged on the count that an edge makes, so the interrupt
  // and the reload land on the same edge and the counter skips the match value.
  wire [1:0] match_pulse = cnt_evt & m_true;
  // Edge-time edges give a capture event; wrap past zero is silent.
  wire [1:0] time_pulse = ev & ~cnt_evt;
  wire [1:0] dma_pulse = (match_pulse | time_pulse) & dma_on;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_ff <= 2'h0;
      dma_ff <= 2'h0;
      capev_ff <= 2'h0;
      cap_ff[0] <= '0;
      cap_ff[1] <= '0;
    end else begin
      irq_ff <= match_pulse;
      dma_ff <= dma_pulse;
      capev_ff <= time_pulse;
      if (time_pulse[0]) begin
        cap_ff[0] <= cnt_ff[0];
        if (CFG_CONCAT) cap_ff[1] <= cnt_ff[1];
      end
      if (time_pulse[1]) cap_ff[1] <= cnt_ff[1];
    end
  end

  assign COUNT = {cnt_ff[1], cnt_ff[0]};
  assign CAPTURE_VALUE = {cap_ff[1], cap_ff[0]};
  assign EVT_A = '{match_irq: irq_ff[0], dma_req: dma_ff[0],
                   capture: capev_ff[0]};
  assign EVT_B = '{match_irq: irq_ff[1], dma_req: dma_ff[1],
                   capture: capev_ff[1]};

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_count_match_a;
    !CFG_CONCAT && !LOAD_STROBE && cnt_evt[0] && at_match[0];
  endsequence

  AST_DEC_ONE: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CFG_CONCAT && !LOAD_STROBE && hit[0] && !at_match[0] && !at_zero[0]
    |=> cnt_ff[0] == $past(cnt_ff[0]) - 16'h0001)
    else $error("Half A did not decrement by one on an edge.");
  AST_NO_EDGE_HOLD: assert property (@(posedge CLK_SYS) disable iff (RST)
    !LOAD_STROBE && ev == 2'h0 && !hit[1] |=> $stable(COUNT))
    else $error("Counter moved without an edge.");
  AST_MATCH_IRQ: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_count_match_a |=> EVT_A.match_irq)
    else $error("Match did not raise interrupt on half A.");
  AST_RELOAD: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_count_match_a |=> cnt_ff[0] == $past(INTERVAL_LOAD_A))
    else $error("Counter not reloaded after match.");
  AST_FULL_MATCH: assert property (@(posedge CLK_SYS) disable iff (RST)
    CFG_CONCAT && !LOAD_STROBE && cnt_evt[0] &&
    full_dec[2*HW-1:HW] != HALF_B_MATCH_VALUE |=> !EVT_A.match_irq)
    else $error("Partial 32-bit agreement raised a match.");
  AST_DMA_GATED: assert property (@(posedge CLK_SYS) disable iff (RST)
    EVT_A.dma_req |-> $past(CFG_A.dma_en))
    else $error("DMA request while DMA disabled.");
  AST_DMA_B: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CFG_CONCAT && hit[1] && CFG_B.dma_en &&
    (!is_count[1] || at_match[1]) |=> EVT_B.dma_req)
    else $error("Half B failed to request DMA.");
  AST_NO_ROLL_DMA: assert property (@(posedge CLK_SYS) disable iff (RST)
    EVT_A.dma_req |-> $past(ev[0]))
    else $error("DMA request without a capture edge.");
  AST_LOAD: assert property (@(posedge CLK_SYS) disable iff (RST)
    LOAD_STROBE |=> COUNT == $past({INTERVAL_LOAD_B, INTERVAL_LOAD_A}))
    else $error("Load strobe did not load the counter.");
  AST_MATCH_B: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CFG_CONCAT && !LOAD_STROBE && cnt_evt[1] && at_match[1]
    |=> EVT_B.match_irq)
    else $error("Match did not raise interrupt on half B.");
  AST_FULL_RELOAD: assert property (@(posedge CLK_SYS) disable iff (RST)
    CFG_CONCAT && !LOAD_STROBE && cnt_evt[0] && full_match_hit
    |=> COUNT == $past(full_load))
    else $error("32-bit counter not reloaded after match.");
  AST_TIME_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CFG_CONCAT && hit[0] && !is_count[0]
    |=> EVT_A.capture && CAPTURE_VALUE[HW-1:0] == $past(cnt_ff[0]))
    else $error("Edge-time edge did not capture the count on half A.");
  AST_DMA_CAUSE_A: assert property (@(posedge CLK_SYS) disable iff (RST)
    EVT_A.dma_req |-> EVT_A.match_irq || EVT_A.capture)
    else $error("Half A requested DMA with no match or capture.");
  AST_DMA_CAUSE_B: assert property (@(posedge CLK_SYS) disable iff (RST)
    EVT_B.dma_req |-> EVT_B.match_irq || EVT_B.capture)
    else $error("Half B requested DMA with no match or capture.");
endmodule

// *** gpt_edge_src.sv ***
// Event source model that drives the two capture pins.
// Assumes the bench calls pulse from its main sequence.
`timescale 1ns/10ps
module gpt_edge_src (
  // Clock
  CLK_SYS,
  // Capture pins
  PIN_A,
  PIN_B
);
  input wire logic CLK_SYS;
  output logic PIN_A;
  output logic PIN_B;
  // ==========================================================
  // Pulse generator
  initial {PIN_A, PIN_B} = 2'b00;
  // Three cycles each way leaves margin over the two the sampler needs.
  task automatic pulse(input bit b);
    repeat (2) begin
      @(posedge CLK_SYS);
      if (b) PIN_B <= ~PIN_B;
      else PIN_A <= ~PIN_A;
      repeat (2) @(posedge CLK_SYS);
    end
  endtask
endmodule

// *** gp_timer_edge_count_match_test.sv ***
// Self-checking bench for the edge-count and edge-time timer.
// Assumes gpt_cfg.svh on the include path and the pin model beside it.
`timescale 1ns/10ps
`include "gpt_cfg.svh"
module gp_timer_edge_count_match_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cfg_concat = 1'b0;
  logic load_strobe = 1'b0;
  gpt_pkg::gpt_half_cfg_t cfg_a = '0;
  gpt_pkg::gpt_half_cfg_t cfg_b = '0;
  logic [15:0] la = 16'h0000, lb = 16'h0000, ma = 16'h0000, mb = 16'h0000;
  logic pin_a, pin_b;
  logic [31:0] count, cap_val;
  gpt_pkg::gpt_half_evt_t evt_a, evt_b;
  int error_cnt = 0, check_count = 0, cyc = 0;
  int na[3], nb[3];
  // ==========================================================
  // Clock, event tally and timeout
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    for (int i = 0; i < 3; i++) begin
      na[i] += (evt_a[i] === 1'b1);
      nb[i] += (evt_b[i] === 1'b1);
    end
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  gpt_edge_src gpt_edge_src_inst (.CLK_SYS(clk_sys), .PIN_A(pin_a),
    .PIN_B(pin_b));
  gpt_timer gpt_timer_inst (.CLK_SYS(clk_sys), .RST(rst),
    .CFG_CONCAT(cfg_concat), .CFG_A(cfg_a), .CFG_B(cfg_b),
    .INTERVAL_LOAD_A(la), .INTERVAL_LOAD_B(lb), .HALF_A_MATCH_VALUE(ma),
    .HALF_B_MATCH_VALUE(mb), .LOAD_STROBE(load_strobe),
    .CAPTURE_INPUT_PIN_A(pin_a), .CAPTURE_INPUT_PIN_B(pin_b),
    .COUNT(count), .CAPTURE_VALUE(cap_val), .EVT_A(evt_a), .EVT_B(evt_b));
  // ==========================================================
  // Shared tasks
  task automatic chk32(string what, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkn(string what, int e, int g);
    check_count++;
    if (g != e) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic setup(bit cc, gpt_pkg::gpt_mode_t m, bit da, bit db,
    logic [15:0] al, logic [15:0] bl, logic [15:0] am, logic [15:0] bm);
    @(posedge clk_sys);
    cfg_concat <= cc;
    cfg_a <= '{m, `GPT_EDGE_POS, 1'b1, da};
    cfg_b <= '{m, `GPT_EDGE_POS, 1'b1, db};
    la <= al;
    lb <= bl;
    ma <= am;
    mb <= bm;
    load_strobe <= 1'b1;
    @(posedge clk_sys);
    load_strobe <= 1'b0;
  endtask
  // One rising edge on a pin, then the pulses seen on that half.
  task automatic hit(bit b, int irq, int dma, int cap);
    #1;
    na = '{0, 0, 0};
    nb = '{0, 0, 0};
    gpt_edge_src_inst.pulse(b);
    repeat (4) @(posedge clk_sys);
    #1;
    chkn("match_irq", irq, b ? nb[2] : na[2]);
    chkn("dma_req", dma, b ? nb[1] : na[1]);
    chkn("capture", cap, b ? nb[0] : na[0]);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_count_a();
    setup(0, gpt_pkg::GPT_MODE_EDGE_COUNT, 1, 0, 16'h0005, 16'h0000,
      16'h0003, 16'h8000);
    hit(0, 0, 0, 0);
    chk32("count", 32'h0000_0004, count);
    hit(0, 1, 1, 0);
    chk32("count", 32'h0000_0005, count);
    hit(0, 0, 0, 0);
    chk32("count", 32'h0000_0004, count);
    $display("test count_a done");
  endtask
  task automatic t_half_b();
    setup(0, gpt_pkg::GPT_MODE_EDGE_COUNT, 0, 1, 16'h0000, 16'h0002,
      16'h8000, 16'h0001);
    hit(1, 1, 1, 0);
    chk32("count", 32'h0002_0000, count);
    setup(0, gpt_pkg::GPT_MODE_EDGE_COUNT, 0, 0, 16'h0000, 16'h0002,
      16'h8000, 16'h0001);
    hit(1, 1, 0, 0);
    setup(0, gpt_pkg::GPT_MODE_OFF, 1, 1, 16'h0007, 16'h0002,
      16'h0006, 16'h0001);
    hit(1, 0, 0, 0);
    chk32("count", 32'h0002_0007, count);
    $display("test half_b done");
  endtask
  task automatic t_concat();
    setup(1, gpt_pkg::GPT_MODE_EDGE_COUNT, 1, 1, 16'h0001, 16'h0001,
      16'h0000, 16'h0000);
    hit(0, 0, 0, 0);
    chk32("count", 32'h0001_0000, count);
    hit(0, 0, 0, 0);
    chk32("count", 32'h0000_FFFF, count);
    setup(1, gpt_pkg::GPT_MODE_EDGE_COUNT, 1, 1, 16'h0002, 16'h0000,
      16'h0001, 16'h0000);
    hit(0, 1, 1, 0);
    chk32("count", 32'h0000_0002, count);
    $display("test concat done");
  endtask
  task automatic t_time();
    setup(0, gpt_pkg::GPT_MODE_EDGE_TIME, 1, 0, 16'h0001, 16'h0000,
      16'h8000, 16'h8000);
    hit(0, 0, 1, 1);
    chk32("count", 32'h0000_0000, count);
    chk32("capture", 32'h0000_0001, cap_val);
    hit(0, 0, 1, 1);
    chk32("count", 32'h0000_0001, count);
    chk32("capture", 32'h0000_0000, cap_val);
    $display("test time done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_count_a();
    t_half_b();
    t_concat();
    t_time();
    conclude();
  end
endmodule
